// >>> verilog/synth_divider_power_control.sv
/*
 * Control logic of a triple synthesizer: serial register loading, divider
 * programming, gain codes, power control, self-tuning and settling
 * tracking, and auxiliary output selection.
 * Assumes the reference input is far slower than clk_sys and that the
 * serial clock is silent while the select line is high.
 */
// Overview of operation
// - R values from registers six, seven, eight
// - N values from registers three, four, five
// - Optional halving of reference before R dividers
// - N split into swallow and main counts
// - Detector updates once per reference over R
// - Two-bit gain code per loop, full to eighth
// - First thirteen update periods are self-tuning
// - Settled about forty periods after trigger
// - Fast update rate caps settling at 100 us
// - RF source follows last written RF divider
// - Low-power bit reduces IF amplifier bias
// - Power pin low turns everything off
// - Pin high: enable bits power each section
// - Reference amplifier on if any enable set
// - Auto power-up acts as both enables set
// - Serial writes accepted in every power state
// - Aux select picks aux output, 11 lock trouble
// - Lock trouble high when selected RF or IF loop tuning, or near limit
// - 22-bit word loaded on select rising edge
// - Tuning restarts on power-up or new frequency
`timescale 1ns/1ps
module synth_divider_power_control
#(
    parameter int SETTLE_MAX_CYCLES = synth_ctrl_pkg::SETTLE_MAX_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic serial_select_n,
    input wire logic serial_data_in,
    input wire logic ref_in,
    input wire logic power_off_pin_n,
    input wire logic rf_range_limit,
    input wire logic if_range_limit,
    output logic rf_output_select,
    output logic if_low_power,
    output logic [1:0] if_divide_code,
    output logic [1:0] rf1_pd_gain_code,
    output logic [1:0] rf2_pd_gain_code,
    output logic [1:0] if_pd_gain_code,
    output logic [4:0] rf1_swallow_count,
    output logic [12:0] rf1_main_count,
    output logic [4:0] rf2_swallow_count,
    output logic [12:0] rf2_main_count,
    output logic [4:0] if_swallow_count,
    output logic [12:0] if_main_count,
    output logic rf1_pd_update,
    output logic rf2_pd_update,
    output logic if_pd_update,
    output logic rf_power_on,
    output logic if_power_on,
    output logic ref_amp_on,
    output logic rf1_tuning,
    output logic rf2_tuning,
    output logic if_tuning,
    output logic rf_settled,
    output logic if_settled,
    output logic lock_trouble_flag,
    output logic aux_out_pin
);
    localparam int P_BITS = synth_ctrl_pkg::PRESCALE_BITS;
    localparam logic [synth_ctrl_pkg::TIME_BITS-1:0] MAX_TIME =
        synth_ctrl_pkg::TIME_BITS'(SETTLE_MAX_CYCLES);
    localparam logic [synth_ctrl_pkg::TIME_BITS-1:0] FAST_LIMIT =
        synth_ctrl_pkg::TIME_BITS'(synth_ctrl_pkg::FAST_PERIOD_CYCLES);
    localparam logic [5:0] TUNE_COUNT = 6'(synth_ctrl_pkg::TUNE_PERIODS);
    localparam logic [5:0] SETTLE_COUNT = 6'(synth_ctrl_pkg::SETTLE_PERIODS);

    serial_word_if word_link ();

    serial_shifter shifter_u
    (
        .sclk(sclk),
        .rstn(rstn),
        .serial_select_n(serial_select_n),
        .serial_data_in(serial_data_in),
        .link(word_link.shifter)
    );

    // Pin synchronisers
    logic [1:0] sel_sync;
    logic [1:0] ref_sync;
    logic [1:0] pin_sync;
    logic [1:0] rf_lim_sync;
    logic [1:0] if_lim_sync;
    logic sel_last;
    logic ref_last;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_sync <= 2'h3;
            ref_sync <= 2'h0;
            pin_sync <= 2'h0;
            rf_lim_sync <= 2'h0;
            if_lim_sync <= 2'h0;
            sel_last <= 1'b1;
            ref_last <= 1'b0;
        end
        else
        begin
            sel_sync <= {sel_sync[0], serial_select_n};
            ref_sync <= {ref_sync[0], ref_in};
            pin_sync <= {pin_sync[0], power_off_pin_n};
            rf_lim_sync <= {rf_lim_sync[0], rf_range_limit};
            if_lim_sync <= {if_lim_sync[0], if_range_limit};
            sel_last <= sel_sync[1];
            ref_last <= ref_sync[1];
        end
    end

    // Word is static here because the serial clock has stopped
    logic load;
    logic [3:0] addr;
    logic [17:0] data;
    assign load = sel_sync[1] && !sel_last;
    assign addr = word_link.word[synth_ctrl_pkg::ADDR_BITS-1:0];
    assign data = word_link.word[synth_ctrl_pkg::WORD_BITS-1:synth_ctrl_pkg::ADDR_BITS];

    logic [17:0] main_configuration;
    logic [17:0] phase_detector_gain;
    logic [17:0] power_control;
    logic [17:0] n_reg [3];
    logic [17:0] r_reg [3];
    logic [2:0] freq_write;

    // Loads take effect whatever the power state
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            main_configuration <= synth_ctrl_pkg::MAIN_RESET;
            phase_detector_gain <= synth_ctrl_pkg::GAIN_RESET;
            power_control <= synth_ctrl_pkg::POWER_RESET;
        end
        else if (load)
        begin
            if (addr == synth_ctrl_pkg::MAIN_CONFIGURATION)
                main_configuration <= data;
            if (addr == synth_ctrl_pkg::PHASE_DETECTOR_GAIN)
                phase_detector_gain <= data;
            if (addr == synth_ctrl_pkg::POWER_CONTROL)
                power_control <= data;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 3; i++)
            begin
                n_reg[i] <= synth_ctrl_pkg::DIVIDER_RESET;
                r_reg[i] <= synth_ctrl_pkg::DIVIDER_RESET;
            end
        end
        else if (load)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (addr == synth_ctrl_pkg::RF1_FEEDBACK_DIVIDER + 4'(i))
                    n_reg[i] <= data;
                if (addr == synth_ctrl_pkg::RF1_REFERENCE_DIVIDER + 4'(i))
                    r_reg[i] <= data;
            end
        end
    end

    always_comb
    begin
        freq_write = 3'h0;
        for (int i = 0; i < 3; i++)
            freq_write[i] = load &&
                (addr == synth_ctrl_pkg::RF1_FEEDBACK_DIVIDER + 4'(i) ||
                 addr == synth_ctrl_pkg::RF1_REFERENCE_DIVIDER + 4'(i));
    end

    // Index 0 is RF1, 1 is RF2, 2 is IF
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rf_output_select <= 1'b0;
        else if (freq_write[0])
            rf_output_select <= 1'b0;
        else if (freq_write[1])
            rf_output_select <= 1'b1;
    end

    // Static fields, registered for clean outputs
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            if_low_power <= 1'b0;
            if_divide_code <= 2'h0;
            rf1_pd_gain_code <= 2'h0;
            rf2_pd_gain_code <= 2'h0;
            if_pd_gain_code <= 2'h0;
        end
        else
        begin
            if_low_power <= main_configuration[synth_ctrl_pkg::LOW_POWER_BIT];
            if_divide_code <= main_configuration[synth_ctrl_pkg::IF_DIV_LSB +: 2];
            rf1_pd_gain_code <= phase_detector_gain[synth_ctrl_pkg::RF1_GAIN_LSB +: 2];
            rf2_pd_gain_code <= phase_detector_gain[synth_ctrl_pkg::RF2_GAIN_LSB +: 2];
            if_pd_gain_code <= phase_detector_gain[synth_ctrl_pkg::IF_GAIN_LSB +: 2];
        end
    end

    // Swallow count is N modulo the prescaler, main count the quotient
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rf1_swallow_count <= '0;
            rf1_main_count <= '0;
            rf2_swallow_count <= '0;
            rf2_main_count <= '0;
            if_swallow_count <= '0;
            if_main_count <= '0;
        end
        else
        begin
            rf1_swallow_count <= n_reg[0][P_BITS-1:0];
            rf1_main_count <= n_reg[0][synth_ctrl_pkg::N_BITS-1:P_BITS];
            rf2_swallow_count <= n_reg[1][P_BITS-1:0];
            rf2_main_count <= n_reg[1][synth_ctrl_pkg::N_BITS-1:P_BITS];
            if_swallow_count <= n_reg[2][P_BITS-1:0];
            if_main_count <= n_reg[2][synth_ctrl_pkg::N_BITS-1:P_BITS];
        end
    end

    // Power state
    logic auto_power_up;
    logic rf_power_en;
    logic if_power_en;
    logic rf_pwr;
    logic if_pwr;
    assign auto_power_up = main_configuration[synth_ctrl_pkg::AUTO_POWER_BIT];
    assign rf_power_en = power_control[synth_ctrl_pkg::RF_POWER_BIT];
    assign if_power_en = power_control[synth_ctrl_pkg::IF_POWER_BIT];
    assign rf_pwr = pin_sync[1] && (auto_power_up || rf_power_en);
    assign if_pwr = pin_sync[1] && (auto_power_up || if_power_en);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rf_power_on <= 1'b0;
            if_power_on <= 1'b0;
            ref_amp_on <= 1'b0;
        end
        else
        begin
            rf_power_on <= rf_pwr;
            if_power_on <= if_pwr;
            ref_amp_on <= rf_pwr || if_pwr;
        end
    end

    // Reference ticks, halved on request
    logic ref_phase;
    logic ref_edge;
    logic ref_tick;
    assign ref_edge = ref_sync[1] && !ref_last;
    assign ref_tick = ref_edge &&
        (!main_configuration[synth_ctrl_pkg::REF_HALVE_BIT] || ref_phase);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            ref_phase <= 1'b0;
        else if (ref_edge)
            ref_phase <= !ref_phase;
    end

    logic [2:0] update;
    logic [2:0] powered;
    logic [2:0] trigger;
    assign powered = {if_pwr, rf_pwr, rf_pwr};

    for (genvar g = 0; g < 3; g++)
    begin : g_ref
        ref_divider div_u
        (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .ref_tick(ref_tick),
            .restart(trigger[g]),
            .r_value(r_reg[g][synth_ctrl_pkg::R_BITS-1:0]),
            .update(update[g])
        );
    end

    assign rf1_pd_update = update[0];
    assign rf2_pd_update = update[1];
    assign if_pd_update = update[2];

    // Tuning restarts on power-up edge or frequency write while powered
    logic [2:0] powered_last;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            powered_last <= 3'h0;
        else
            powered_last <= powered;
    end
    assign trigger = (powered & ~powered_last) | (powered & freq_write);

    logic [5:0] periods [3];
    logic [15:0] elapsed [3];
    logic [15:0] gap [3];
    logic [2:0] fast;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 3; i++)
            begin
                periods[i] <= '0;
                elapsed[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (trigger[i] || !powered[i])
                begin
                    periods[i] <= '0;
                    elapsed[i] <= '0;
                end
                else
                begin
                    if (update[i] && periods[i] < SETTLE_COUNT)
                        periods[i] <= periods[i] + 6'h01;
                    if (elapsed[i] < MAX_TIME)
                        elapsed[i] <= elapsed[i] + 16'h0001;
                end
            end
        end
    end

    // Update rate measured from spacing of update pulses
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 3; i++)
            begin
                gap[i] <= '0;
                fast[i] <= 1'b0;
            end
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (update[i])
                begin
                    gap[i] <= '0;
                    fast[i] <= gap[i] < FAST_LIMIT;
                end
                else if (gap[i] != 16'hFFFF)
                    gap[i] <= gap[i] + 16'h0001;
            end
        end
    end

    logic [2:0] tuning;
    logic [2:0] settled;
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            tuning[i] = powered[i] && periods[i] < TUNE_COUNT;
            // Time cap never cuts tuning short
            settled[i] = powered[i] && !tuning[i] && (periods[i] >= SETTLE_COUNT ||
                (fast[i] && elapsed[i] >= MAX_TIME));
        end
    end

    logic rf_busy;
    logic trouble;
    assign rf_busy = rf_output_select ? tuning[1] : tuning[0];
    assign trouble = rf_busy || tuning[2] ||
        (rf_pwr && rf_lim_sync[1]) || (if_pwr && if_lim_sync[1]);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rf1_tuning <= 1'b0;
            rf2_tuning <= 1'b0;
            if_tuning <= 1'b0;
            rf_settled <= 1'b0;
            if_settled <= 1'b0;
            lock_trouble_flag <= 1'b0;
            aux_out_pin <= 1'b0;
        end
        else
        begin
            rf1_tuning <= tuning[0];
            rf2_tuning <= tuning[1];
            if_tuning <= tuning[2];
            rf_settled <= rf_output_select ? settled[1] : settled[0];
            if_settled <= settled[2];
            lock_trouble_flag <= trouble;
            // Only the lock-trouble code drives a level; others hold low
            aux_out_pin <= (main_configuration[synth_ctrl_pkg::AUX_SEL_LSB +: 2]
                == synth_ctrl_pkg::AUX_LOCK_TROUBLE) && trouble;
        end
    end
endmodule : synth_divider_power_control

// >>> verilog/synth_ctrl_pkg.sv
/*
 * Shared constants of the triple synthesizer control block: register map,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and a slow reference input.
 */
package synth_ctrl_pkg;
    localparam int WORD_BITS = 22;
    localparam int DATA_BITS = 18;
    localparam int ADDR_BITS = 4;
    localparam int R_BITS = 13;
    localparam int N_BITS = 18;

    // Register indices on the serial address field
    localparam logic [3:0] MAIN_CONFIGURATION = 4'h0;
    localparam logic [3:0] PHASE_DETECTOR_GAIN = 4'h1;
    localparam logic [3:0] POWER_CONTROL = 4'h2;
    localparam logic [3:0] RF1_FEEDBACK_DIVIDER = 4'h3;
    localparam logic [3:0] RF2_FEEDBACK_DIVIDER = 4'h4;
    localparam logic [3:0] IF_FEEDBACK_DIVIDER = 4'h5;
    localparam logic [3:0] RF1_REFERENCE_DIVIDER = 4'h6;
    localparam logic [3:0] RF2_REFERENCE_DIVIDER = 4'h7;
    localparam logic [3:0] IF_REFERENCE_DIVIDER = 4'h8;

    // Main configuration fields
    localparam int AUX_SEL_LSB = 12;
    localparam int IF_DIV_LSB = 10;
    localparam int REF_HALVE_BIT = 6;
    localparam int LOW_POWER_BIT = 5;
    localparam int AUTO_POWER_BIT = 3;
    // Gain fields
    localparam int RF1_GAIN_LSB = 0;
    localparam int RF2_GAIN_LSB = 2;
    localparam int IF_GAIN_LSB = 4;
    // Power control fields
    localparam int RF_POWER_BIT = 0;
    localparam int IF_POWER_BIT = 1;

    // Values after reset
    localparam logic [17:0] MAIN_RESET = 18'h00302;
    localparam logic [17:0] GAIN_RESET = 18'h00000;
    localparam logic [17:0] POWER_RESET = 18'h00000;
    localparam logic [17:0] DIVIDER_RESET = 18'h00001;

    // Auxiliary output codes
    localparam logic [1:0] AUX_FORCE_LOW = 2'h1;
    localparam logic [1:0] AUX_LOCK_TROUBLE = 2'h3;

    // Prescaler modulus of the feedback divider
    localparam int PRESCALE_BITS = 5;

    // Settling in update periods
    localparam int TUNE_PERIODS = 13;
    localparam int LOOP_PERIODS = 25;
    localparam int SETTLE_PERIODS = TUNE_PERIODS + LOOP_PERIODS + 2;
    localparam int PERIOD_COUNT_BITS = 6;

    // Time limits
    localparam int CLK_PERIOD_NS = 10;
    localparam int FAST_RATE_KHZ = 500;
    localparam int FAST_PERIOD_CYCLES = 1000000 / FAST_RATE_KHZ / CLK_PERIOD_NS;
    localparam int SETTLE_MAX_US = 100;
    localparam int SETTLE_MAX_CYCLES = SETTLE_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int TIME_BITS = 16;
endpackage : synth_ctrl_pkg

// >>> verilog/serial_word_if.sv
/*
 * Carries the assembled serial word from the link-clock shifter to the
 * register logic.
 * Assumes the word is static while the select line is high.
 */
`timescale 1ns/1ps
interface serial_word_if;
    logic [synth_ctrl_pkg::WORD_BITS-1:0] word;
    modport shifter (output word);
    modport sink (input word);
endinterface : serial_word_if

// >>> verilog/serial_shifter.sv
/*
 * Serial input shift register clocked by the link's serial clock.
 * Assumes the serial clock only runs while the select line is low.
 */
`timescale 1ns/1ps
module serial_shifter
(
    input wire logic sclk,
    input wire logic rstn,
    input wire logic serial_select_n,
    input wire logic serial_data_in,
    serial_word_if.shifter link
);
    always_ff @(posedge sclk or negedge rstn)
    begin
        if (!rstn)
            link.word <= '0;
        else if (!serial_select_n)
            link.word <= {link.word[synth_ctrl_pkg::WORD_BITS-2:0], serial_data_in};
    end
endmodule : serial_shifter

// >>> verilog/ref_divider.sv
/*
 * Reference R counter of one loop: one update pulse every R reference ticks.
 * Assumes ref_tick is a one-cycle pulse on clk_sys.
 */
`timescale 1ns/1ps
module ref_divider
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ref_tick,
    input wire logic restart,
    input wire logic [synth_ctrl_pkg::R_BITS-1:0] r_value,
    output logic update
);
    logic [synth_ctrl_pkg::R_BITS-1:0] count;
    logic last;

    // R of zero behaves as one
    assign last = (count + 1'b1 >= r_value);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            count <= '0;
        else if (restart)
            count <= '0;
        else if (ref_tick)
            count <= last ? '0 : count + 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            update <= 1'b0;
        else
            update <= ref_tick && last && !restart;
    end
endmodule : ref_divider

// >>> tb/synth_ctrl_properties.sv
/*
 * Port checker of the synthesizer control block.
 * Assumes binding onto every synth_divider_power_control instance.
 */
`timescale 1ns/1ps
module synth_ctrl_properties
#(
    parameter int SETTLE_MAX_CYCLES = 300
)
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic power_off_pin_n,
    input wire logic rf_power_on,
    input wire logic if_power_on,
    input wire logic ref_amp_on,
    input wire logic rf1_pd_update,
    input wire logic if_tuning,
    input wire logic if_settled,
    input wire logic lock_trouble_flag,
    input wire logic aux_out_pin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Five samples: two synchroniser stages plus the output register
    a_pin_all_off: assert property (
        (!power_off_pin_n)[*5] |-> !rf_power_on && !if_power_on)
        else $error("Power on while pin low");
    a_ref_amp_any: assert property (
        ref_amp_on == (rf_power_on || if_power_on))
        else $error("Reference amplifier mismatch");
    a_update_single: assert property (
        rf1_pd_update |=> !rf1_pd_update)
        else $error("Update pulse too long");
    a_tune_holds: assert property (
        $rose(if_tuning) |=> (if_tuning || !if_power_on)[*8])
        else $error("Tuning ended early");
    a_tune_lock: assert property (
        $past(if_tuning) && if_tuning |-> lock_trouble_flag)
        else $error("Lock trouble low while tuning");
    a_settle_after: assert property (
        if_settled |-> !if_tuning)
        else $error("Settled while tuning");
    a_aux_lock: assert property (
        aux_out_pin |-> lock_trouble_flag || $past(lock_trouble_flag))
        else $error("Aux high without lock trouble");
    a_tune_power: assert property (
        if_tuning |-> if_power_on || $past(if_power_on))
        else $error("Tuning while unpowered");
endmodule : synth_ctrl_properties

bind synth_divider_power_control synth_ctrl_properties #(
    .SETTLE_MAX_CYCLES(SETTLE_MAX_CYCLES)
) props (
    .clk_sys(clk_sys), .rstn(rstn), .power_off_pin_n(power_off_pin_n),
    .rf_power_on(rf_power_on), .if_power_on(if_power_on), .ref_amp_on(ref_amp_on),
    .rf1_pd_update(rf1_pd_update), .if_tuning(if_tuning), .if_settled(if_settled),
    .lock_trouble_flag(lock_trouble_flag), .aux_out_pin(aux_out_pin)
);

// >>> tb/host_serial_model.sv
/*
 * Host side of the serial link: shifts 22-bit words on a 160 ns clock.
 * Assumes the device loads the word when select rises.
 */
`timescale 1ns/1ps
module host_serial_model
(
    output logic sclk,
    output logic serial_select_n,
    output logic serial_data_in
);
    initial
    begin
        sclk = 1'b0;
        serial_select_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // Clock still between frames; released data shows the inverse
    task automatic send(input logic [3:0] addr, input logic [17:0] data);
        logic [21:0] word;
        word = {data, addr};
        serial_select_n = 1'b0;
        for (int i = 21; i >= 0; i--)
        begin
            serial_data_in = word[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        serial_select_n = 1'b1;
        serial_data_in = ~word[0];
        #400;
    endtask : send
endmodule : host_serial_model

// >>> tb/tb.sv
/*
 * Self-checking bench of the synthesizer control block.
 * Assumes the host model drives the serial pins on its own clock.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t: got %0h want %0h", $time, g, e); end end
module tb;
    logic clk_sys, rstn, sclk, serial_select_n, serial_data_in, ref_in, power_off_pin_n;
    logic rf_range_limit, if_range_limit, rf_output_select, if_low_power, rf1_pd_update;
    logic rf2_pd_update, if_pd_update, rf_power_on, if_power_on, ref_amp_on, rf1_tuning;
    logic rf2_tuning, if_tuning, rf_settled, if_settled, lock_trouble_flag, aux_out_pin;
    logic [1:0] if_divide_code, rf1_pd_gain_code, rf2_pd_gain_code, if_pd_gain_code;
    logic [4:0] rf1_swallow_count, rf2_swallow_count, if_swallow_count;
    logic [12:0] rf1_main_count, rf2_main_count, if_main_count;
    logic [35:0] expq[$];
    logic [31:0] meas;
    logic [17:0] n;
    logic [1:0] g;
    int failures = 0, checked = 0, ph = 0;
    synth_divider_power_control #(.SETTLE_MAX_CYCLES(300)) dut (.*);
    host_serial_model host (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // 100 ns reference: slow enough for the input synchronisers
    always @(negedge clk_sys)
    begin
        ph <= (ph + 1) % 5;
        if (ph == 4)
            ref_in <= ~ref_in;
    end
    function automatic logic [31:0] obs(input logic [3:0] k);
        case (k)
            4'h0: return 32'({rf1_pd_gain_code, rf2_pd_gain_code, if_pd_gain_code});
            4'h1: return 32'({rf1_main_count, rf1_swallow_count});
            4'h2: return 32'({rf2_main_count, rf2_swallow_count});
            4'h3: return 32'({if_main_count, if_swallow_count});
            4'h4: return 32'({rf_power_on, if_power_on, ref_amp_on});
            4'h5: return 32'(rf_output_select);
            4'h6: return 32'({if_divide_code, if_low_power});
            4'h7: return 32'({aux_out_pin, lock_trouble_flag});
            4'h9: return 32'({rf1_tuning, rf2_tuning, rf_settled});
            default: return meas;
        endcase
    endfunction : obs
    always @(negedge clk_sys)
        while (expq.size() > 0)
        begin
            `CHK(obs(expq[0][35:32]), expq[0][31:0])
            void'(expq.pop_front());
        end
    // RF1 lags the others by one step below 16384
    function automatic logic [1:0] gain_for(input logic [17:0] v, input bit late);
        logic [1:0] s;
        s = (v < 2048) ? 2'h0 : (v < 4096) ? 2'h1 : (v < 8192) ? 2'h2 : 2'h3;
        if (late && v < 16384 && s != 2'h0)
            s = s - 2'h1;
        return s;
    endfunction : gain_for
    task automatic wr(input logic [3:0] a, input logic [17:0] d);
        host.send(a, d);
        @(negedge clk_sys);
    endtask : wr
    task automatic stuck;
        failures++;
        $display("BAD %0t: wait ran out", $time);
        test_done();
    endtask : stuck
    task automatic gap;
        int c;
        int seen;
        seen = 0;
        meas = 32'h0;
        for (c = 0; seen < 2 && c < 2000; c++)
        begin
            @(negedge clk_sys);
            if (rf1_pd_update === 1'b1)
            begin
                seen++;
                meas = 32'(c) - meas;
            end
        end
        if (seen < 2)
            stuck();
    endtask : gap
    task automatic tally(input bit settle);
        int c;
        for (c = 0; c < 20000; c++)
        begin
            @(negedge clk_sys);
            if (if_pd_update === 1'b1)
                meas++;
            if (settle ? if_settled === 1'b1 : if_tuning !== 1'b1)
                break;
        end
        if (c == 20000)
            stuck();
    endtask : tally
    task automatic test_done;
        $display("Compared %0d, mismatched %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial
    begin
        rstn = 1'b0;
        ref_in = 1'b0;
        power_off_pin_n = 1'b1;
        rf_range_limit = 1'b0;
        if_range_limit = 1'b0;
        void'($urandom(54));
        repeat (10) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (5) @(negedge clk_sys);
        expq.push_back({4'h1, 32'h1});
        expq.push_back({4'h4, 32'h0});
        $display("Test reset done");
        for (int i = 0; i < 5; i++)
        begin
            n = 18'($urandom_range(2047, 1024)) << i;
            for (int k = 0; k < 3; k++)
            begin
                wr(4'(3 + k), n);
                expq.push_back({4'(1 + k), 32'(n)});
            end
            g = gain_for(n, 1'b0);
            wr(4'h1, {12'h0, g, g, gain_for(n, 1'b1)});
            expq.push_back({4'h0, 32'({gain_for(n, 1'b1), g, g})});
        end
        expq.push_back({4'h5, 32'h1});
        wr(4'h6, 18'h3);
        expq.push_back({4'h5, 32'h0});
        $display("Test dividers done");
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h0, 18'h00302 | 18'(i << 10) | (18'(i & 1) << 5));
            expq.push_back({4'h6, 32'({2'(i), i[0]})});
        end
        for (int i = 0; i < 16; i++)
        begin
            power_off_pin_n = 1'b0;
            wr(4'h0, 18'h00302 | (18'(i & 4) << 1));
            wr(4'h2, 18'(i & 3));
            power_off_pin_n = i[3];
            repeat (6) @(negedge clk_sys);
            g = {i[3] & (i[2] | i[0]), i[3] & (i[2] | i[1])};
            expq.push_back({4'h4, 32'({g, |g})});
        end
        $display("Test power done");
        gap();
        expq.push_back({4'h8, 32'h1E});
        wr(4'h0, 18'h0034A);
        gap();
        expq.push_back({4'h8, 32'h3C});
        $display("Test updates done");
        // Slow IF updates keep the settling count off the time cap
        wr(4'h0, 18'h0330A);
        wr(4'h8, 18'h19);
        wr(4'h5, n);
        expq.push_back({4'h7, 32'h3});
        meas = 32'h0;
        tally(1'b0);
        expq.push_back({4'h8, 32'hD});
        tally(1'b1);
        expq.push_back({4'h8, 32'h28});
        repeat (4) @(negedge clk_sys);
        expq.push_back({4'h7, 32'h0});
        for (int i = 0; i < 2; i++)
        begin
            {rf_range_limit, if_range_limit} = 2'(i + 1);
            repeat (6) @(negedge clk_sys);
            expq.push_back({4'h7, 32'h3});
        end
        wr(4'h0, 18'h0130A);
        expq.push_back({4'h7, 32'h1});
        // Fast RF2 updates: time cap settles it before forty periods
        wr(4'h7, 18'h1);
        repeat (30) @(negedge clk_sys);
        expq.push_back({4'h9, 32'h2});
        repeat (270) @(negedge clk_sys);
        expq.push_back({4'h9, 32'h1});
        $display("Test tuning done");
        repeat (2) @(negedge clk_sys);
        test_done();
    end
endmodule : tb
